// ---- logic/tfhi_pkg.sv ----
package tfhi_pkg;
    // Clock and timing figures, each time in its own unit.
    localparam int CLK_MHZ = 40;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int WIN_LO_MS = 16;
    localparam int WIN_HI_MS = 4;
    localparam int REPOS_MS = 400;
    localparam int WIN_LO_CYC = WIN_LO_MS * CYC_PER_MS;
    localparam int WIN_HI_CYC = WIN_HI_MS * CYC_PER_MS;
    localparam int REPOS_CYC = REPOS_MS * CYC_PER_MS;
    localparam int CNT_W = 24;
    localparam int PCNT_W = 6;

    // Synchronised pin vector layout.
    localparam int PIN_W = 23;
    localparam int PIN_PAR = 8;
    localparam int PIN_GO = 9;
    localparam int PIN_ABORT = 10;
    localparam int PIN_SPD = 11;
    localparam int PIN_LWD = 12;
    localparam int PIN_REW = 13;
    localparam int PIN_RWU = 14;
    localparam int PIN_CMD_LSB = 15;
    localparam int PIN_ADR_LSB = 20;

    // Command code bits: reverse, write, file mark, edit, erase.
    localparam int CMD_REV = 0;
    localparam int CMD_WRT = 1;
    localparam int CMD_ERASE = 4;

    // Register offsets and answers.
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CONFIG = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_EVENT = 5'h08;
    localparam logic [4:0] OFF_RDATA = 5'h0c;
    localparam logic [4:0] OFF_WDATA = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Configuration fields.
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam int CFG_CORR = 3;
    localparam int CFG_TENS = 4;
    localparam int CFG_LDP = 5;
    localparam int CFG_EOT = 6;
    localparam int CFG_FPT = 7;
    localparam int CFG_ONL = 8;
    localparam int CFG_LOAD = 9;

    // Event bits, write one to pulse.
    localparam int EV_DONE = 0;
    localparam int EV_FMK = 1;
    localparam int EV_DROP = 2;
    localparam int EV_HARD = 3;
    localparam int EV_IDENT = 4;
    localparam int EV_RWD = 5;
    localparam int EV_WSTR = 6;

    // Status fields.
    localparam int ST_CMD = 0;
    localparam int ST_SPD = 5;
    localparam int ST_CUR = 6;
    localparam int ST_DBY = 7;
    localparam int ST_FBY = 8;
    localparam int ST_STATE = 9;
    localparam int ST_RDY = 14;
    localparam int ST_SEL = 15;
    localparam int WD_LWD = 9;

    typedef enum logic [4:0] {
        TFHI_IDLE = 5'h01,
        TFHI_REPOS = 5'h02,
        TFHI_RUN = 5'h04,
        TFHI_WINDOW = 5'h08,
        TFHI_REWIND = 5'h10
    } tfhi_state_t;
endpackage : tfhi_pkg

// ---- logic/tfhi_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
module tfhi_drive #(
    parameter int unsigned WIN_LO_CYC = tfhi_pkg::WIN_LO_CYC,
    parameter int unsigned WIN_HI_CYC = tfhi_pkg::WIN_HI_CYC,
    parameter int unsigned REPOS_CYC = tfhi_pkg::REPOS_CYC
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic unit_addr_high_n_i,
    input wire logic unit_addr_mid_n_i,
    input wire logic unit_addr_low_n_i,
    input wire logic runaway_abort_n_i,
    input wire logic command_strobe_n_i,
    input wire logic speed_select_in_n_i,
    input wire logic last_char_flag_n_i,
    input wire logic rewind_pulse_n_i,
    input wire logic rewind_unload_pulse_n_i,
    input wire logic [7:0] write_data_n_i,
    input wire logic write_parity_bit_n_i,
    input wire logic write_cmd_line_n_i,
    input wire logic reverse_cmd_line_n_i,
    input wire logic filemark_cmd_line_n_i,
    input wire logic edit_cmd_line_n_i,
    input wire logic erase_cmd_line_n_i,
    output logic write_strobe_out_n_o,
    output logic read_strobe_out_n_o,
    output logic [7:0] read_data_n_o,
    output logic read_parity_bit_n_o,
    output logic data_busy_out_n_o,
    output logic formatter_busy_out_n_o,
    output logic corrected_error_out_n_o,
    output logic hard_error_out_n_o,
    output logic filemark_seen_out_n_o,
    output logic id_burst_out_n_o,
    output logic end_of_tape_out_n_o,
    output logic load_point_out_n_o,
    output logic write_protect_out_n_o,
    output logic online_out_n_o,
    output logic drive_ready_out_n_o,
    output logic rewinding_out_n_o,
    output logic high_speed_out_n_o,
    output logic status_oe_o
);
    localparam int CW = tfhi_pkg::CNT_W;
    localparam int PW = tfhi_pkg::PCNT_W;
    localparam logic [PW-1:0] PULSE = PW'(tfhi_pkg::PULSE_CYC);
    localparam logic [PW-1:0] PONE = 6'h01;

    logic [tfhi_pkg::PIN_W-1:0] pin_raw;
    logic [tfhi_pkg::PIN_W-1:0] pin_s1_ff;
    logic [tfhi_pkg::PIN_W-1:0] pin_s2_ff;
    logic [tfhi_pkg::PIN_W-1:0] pin_d_ff;
    logic [31:0] cfg_ff;
    logic [4:0] cmd_ff;
    logic spd_ff;
    logic cur_spd_ff;
    logic dbusy_ff;
    logic fbusy_ff;
    logic corr_ff;
    logic hard_ff;
    logic ident_ff;
    tfhi_pkg::tfhi_state_t state_ff;
    logic [CW-1:0] cnt_ff;
    logic [PW-1:0] wstr_cnt_ff;
    logic [PW-1:0] rstr_cnt_ff;
    logic [PW-1:0] fmk_cnt_ff;
    logic [9:0] wchar_ff;
    logic [8:0] rchar_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [4:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] wmask;
    logic do_wr;
    logic [31:0] ev;
    logic rd_wr;
    logic [31:0] status_w;
    logic sel;
    logic go_lvl;
    logic go_fall;
    logic abort_ev;
    logic rew_acc;
    logic rwu_acc;
    logic ready;
    logic go_acc;
    logic same_cmd;
    logic need_repos;
    logic hold;
    logic win_exp;
    logic done;
    logic [4:0] code_in;
    logic spd_in;

    // Pins pass two flops; inverting here keeps all later logic active high.
    // low true pins
    assign pin_raw = {unit_addr_high_n_i, unit_addr_mid_n_i, unit_addr_low_n_i, erase_cmd_line_n_i,
                      edit_cmd_line_n_i, filemark_cmd_line_n_i, write_cmd_line_n_i, reverse_cmd_line_n_i,
                      rewind_unload_pulse_n_i, rewind_pulse_n_i, last_char_flag_n_i, speed_select_in_n_i,
                      runaway_abort_n_i, command_strobe_n_i, write_parity_bit_n_i, write_data_n_i};
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_d_ff <= '0;
        end else begin
            pin_s1_ff <= ~pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff <= pin_s2_ff;
        end
    end

    // Unit decode and edge detection on the synchronised lines.
    // unit match
    assign sel = pin_s2_ff[tfhi_pkg::PIN_ADR_LSB +: 3] == cfg_ff[2:0];
    assign go_lvl = pin_s2_ff[tfhi_pkg::PIN_GO];
    assign go_fall = !go_lvl && pin_d_ff[tfhi_pkg::PIN_GO];
    assign abort_ev = sel && !pin_s2_ff[tfhi_pkg::PIN_ABORT] && pin_d_ff[tfhi_pkg::PIN_ABORT];
    assign code_in = pin_s2_ff[tfhi_pkg::PIN_CMD_LSB +: 5];
    assign spd_in = pin_s2_ff[tfhi_pkg::PIN_SPD];
    assign ready = cfg_ff[tfhi_pkg::CFG_TENS] && cfg_ff[tfhi_pkg::CFG_ONL] && !cfg_ff[tfhi_pkg::CFG_LOAD]
                   && state_ff != tfhi_pkg::TFHI_REWIND;

    // Commands are taken only at the strobe's trailing edge by a selected drive that is idle or in its reinstruct window.
    // trailing edge start
    assign go_acc = sel && go_fall && ready && !dbusy_ff && !abort_ev
                    && (state_ff == tfhi_pkg::TFHI_IDLE || state_ff == tfhi_pkg::TFHI_WINDOW);
    assign rew_acc = sel && !pin_s2_ff[tfhi_pkg::PIN_REW] && pin_d_ff[tfhi_pkg::PIN_REW] && ready
                     && !dbusy_ff && !cfg_ff[tfhi_pkg::CFG_LDP] && !go_acc;
    assign rwu_acc = sel && !pin_s2_ff[tfhi_pkg::PIN_RWU] && pin_d_ff[tfhi_pkg::PIN_RWU] && ready
                     && !dbusy_ff && !go_acc;
    assign same_cmd = code_in == cmd_ff && spd_in == spd_ff;
    assign need_repos = go_acc && ((state_ff == tfhi_pkg::TFHI_IDLE && spd_in != cur_spd_ff)
                        || (state_ff == tfhi_pkg::TFHI_WINDOW && !same_cmd));
    assign hold = sel && go_lvl;
    assign win_exp = state_ff == tfhi_pkg::TFHI_WINDOW && !go_acc && !hold && !rew_acc && !rwu_acc
                     && cnt_ff == '0;
    assign done = state_ff == tfhi_pkg::TFHI_RUN
                  && (ev[tfhi_pkg::EV_DONE] || (wstr_cnt_ff == PONE && wchar_ff[tfhi_pkg::WD_LWD]));

    // Motion sequencer.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= tfhi_pkg::TFHI_IDLE;
        end else if (abort_ev) begin
            state_ff <= tfhi_pkg::TFHI_IDLE;
        end else begin
            case (state_ff)
                tfhi_pkg::TFHI_IDLE, tfhi_pkg::TFHI_WINDOW: begin
                    if (need_repos) begin
                        state_ff <= tfhi_pkg::TFHI_REPOS;
                    end else if (go_acc) begin
                        state_ff <= tfhi_pkg::TFHI_RUN;
                    end else if (rew_acc || rwu_acc) begin
                        state_ff <= tfhi_pkg::TFHI_REWIND;
                    end else if (win_exp) begin
                        state_ff <= tfhi_pkg::TFHI_IDLE;
                    end
                end
                tfhi_pkg::TFHI_REPOS: begin
                    if (cnt_ff == '0) begin
                        state_ff <= tfhi_pkg::TFHI_RUN;
                    end
                end
                tfhi_pkg::TFHI_RUN: begin
                    if (done) begin
                        state_ff <= tfhi_pkg::TFHI_WINDOW;
                    end
                end
                tfhi_pkg::TFHI_REWIND: begin
                    if (ev[tfhi_pkg::EV_RWD]) begin
                        state_ff <= tfhi_pkg::TFHI_IDLE;
                    end
                end
                default: begin
                    state_ff <= tfhi_pkg::TFHI_IDLE;
                end
            endcase
        end
    end

    // One down counter serves both repositioning and the reinstruct window.
    // window length by speed
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= '0;
        end else if (need_repos) begin
            cnt_ff <= CW'(REPOS_CYC - 1);
        end else if (done) begin
            cnt_ff <= spd_ff ? CW'(WIN_HI_CYC - 1) : CW'(WIN_LO_CYC - 1);
        end else if ((state_ff == tfhi_pkg::TFHI_REPOS || (state_ff == tfhi_pkg::TFHI_WINDOW && !hold))
                     && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Command and speed latch; the running speed follows after repositioning.
    // latch command lines
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_ff <= '0;
            spd_ff <= 1'b0;
            cur_spd_ff <= 1'b0;
        end else begin
            if (go_acc) begin
                cmd_ff <= code_in;
                spd_ff <= spd_in;
            end
            if (state_ff == tfhi_pkg::TFHI_REPOS && cnt_ff == '0) begin
                cur_spd_ff <= spd_ff;
            end
        end
    end

    // Busy flags; abort drops both at once.
    // data busy span
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dbusy_ff <= 1'b0;
            fbusy_ff <= 1'b0;
        end else begin
            dbusy_ff <= go_acc || (dbusy_ff && !done && !abort_ev);
            fbusy_ff <= go_acc || (fbusy_ff && !win_exp && !abort_ev);
        end
    end

    // Error flags: a set needs data busy, so none lands in the cycle a new command clears them.
    // corrected error
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            corr_ff <= 1'b0;
            hard_ff <= 1'b0;
            ident_ff <= 1'b0;
        end else begin
            corr_ff <= (corr_ff && !go_acc) || (ev[tfhi_pkg::EV_DROP] && dbusy_ff && cfg_ff[tfhi_pkg::CFG_CORR]);
            hard_ff <= (hard_ff && !go_acc) || (ev[tfhi_pkg::EV_HARD] && dbusy_ff && !cmd_ff[tfhi_pkg::CMD_ERASE]);
            ident_ff <= (ident_ff && !go_acc) || (ev[tfhi_pkg::EV_IDENT] && dbusy_ff);
        end
    end

    // Pulse generators, each at least one microsecond wide.
    // write strobe width
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wstr_cnt_ff <= '0;
            rstr_cnt_ff <= '0;
            fmk_cnt_ff <= '0;
            wchar_ff <= '0;
            rchar_ff <= '0;
        end else begin
            if (ev[tfhi_pkg::EV_WSTR] && state_ff == tfhi_pkg::TFHI_RUN && cmd_ff[tfhi_pkg::CMD_WRT]
                && wstr_cnt_ff == '0) begin
                wstr_cnt_ff <= PULSE;
                wchar_ff <= {pin_s2_ff[tfhi_pkg::PIN_LWD], pin_s2_ff[tfhi_pkg::PIN_PAR:0]};
            end else if (wstr_cnt_ff != '0) begin
                wstr_cnt_ff <= wstr_cnt_ff - PONE;
            end
            if (rd_wr && state_ff == tfhi_pkg::TFHI_RUN && !cmd_ff[tfhi_pkg::CMD_ERASE] && rstr_cnt_ff == '0) begin
                rstr_cnt_ff <= PULSE;
                rchar_ff <= wdata_ff[8:0];
            end else if (rstr_cnt_ff != '0) begin
                rstr_cnt_ff <= rstr_cnt_ff - PONE;
            end
            if (ev[tfhi_pkg::EV_FMK] && dbusy_ff && fmk_cnt_ff == '0) begin
                fmk_cnt_ff <= PULSE;
            end else if (fmk_cnt_ff != '0) begin
                fmk_cnt_ff <= fmk_cnt_ff - PONE;
            end
        end
    end

    // Bus slave: address and data are caught in either order, then written together.
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign ev = (do_wr && awaddr_ff == tfhi_pkg::OFF_EVENT) ? (wdata_ff & wmask) : 32'h0000_0000;
    assign rd_wr = do_wr && awaddr_ff == tfhi_pkg::OFF_RDATA;
    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tfhi_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_ff == tfhi_pkg::OFF_CONFIG || awaddr_ff == tfhi_pkg::OFF_STATUS
                    || awaddr_ff == tfhi_pkg::OFF_EVENT || awaddr_ff == tfhi_pkg::OFF_RDATA
                    || awaddr_ff == tfhi_pkg::OFF_WDATA) begin
                    s_axi_bresp <= tfhi_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= tfhi_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration register; a rewind-unload clears the online bit.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_ff <= tfhi_pkg::CFG_RESET;
        end else if (do_wr && awaddr_ff == tfhi_pkg::OFF_CONFIG) begin
            cfg_ff <= (wdata_ff & wmask) | (cfg_ff & ~wmask);
        end else if (rwu_acc) begin
            cfg_ff[tfhi_pkg::CFG_ONL] <= 1'b0;
        end
    end

    // Status word gathers the block's own state for software.
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[tfhi_pkg::ST_CMD +: 5] = cmd_ff;
        status_w[tfhi_pkg::ST_SPD] = spd_ff;
        status_w[tfhi_pkg::ST_CUR] = cur_spd_ff;
        status_w[tfhi_pkg::ST_DBY] = dbusy_ff;
        status_w[tfhi_pkg::ST_FBY] = fbusy_ff;
        status_w[tfhi_pkg::ST_STATE +: 5] = state_ff;
        status_w[tfhi_pkg::ST_RDY] = ready;
        status_w[tfhi_pkg::ST_SEL] = sel;
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tfhi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tfhi_pkg::RESP_OKAY;
            if (s_axi_araddr == tfhi_pkg::OFF_CONFIG) begin
                s_axi_rdata <= cfg_ff;
            end else if (s_axi_araddr == tfhi_pkg::OFF_STATUS) begin
                s_axi_rdata <= status_w;
            end else if (s_axi_araddr == tfhi_pkg::OFF_EVENT) begin
                s_axi_rdata <= 32'h0000_0000;
            end else if (s_axi_araddr == tfhi_pkg::OFF_RDATA) begin
                s_axi_rdata <= {23'h000000, rchar_ff};
            end else if (s_axi_araddr == tfhi_pkg::OFF_WDATA) begin
                s_axi_rdata <= {22'h000000, wchar_ff};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= tfhi_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pin drivers are low true; the enable keeps an unselected unit off the chain.
    // bus released when unselected
    assign status_oe_o = sel;
    assign write_strobe_out_n_o = wstr_cnt_ff == '0;
    assign read_strobe_out_n_o = rstr_cnt_ff == '0;
    assign read_data_n_o = ~rchar_ff[7:0];
    assign read_parity_bit_n_o = ~rchar_ff[8];
    assign data_busy_out_n_o = !dbusy_ff;
    assign formatter_busy_out_n_o = !fbusy_ff;
    assign corrected_error_out_n_o = !corr_ff;
    assign hard_error_out_n_o = !hard_ff;
    assign filemark_seen_out_n_o = fmk_cnt_ff == '0;
    assign id_burst_out_n_o = !ident_ff;
    assign end_of_tape_out_n_o = !cfg_ff[tfhi_pkg::CFG_EOT];
    assign load_point_out_n_o = !cfg_ff[tfhi_pkg::CFG_LDP];
    assign write_protect_out_n_o = !cfg_ff[tfhi_pkg::CFG_FPT];
    assign online_out_n_o = !cfg_ff[tfhi_pkg::CFG_ONL];
    assign drive_ready_out_n_o = !ready;
    assign rewinding_out_n_o = state_ff != tfhi_pkg::TFHI_REWIND;
    assign high_speed_out_n_o = !cur_spd_ff;
endmodule : tfhi_drive
`default_nettype wire

// ---- bench/tfhi_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tfhi_properties (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic runaway_abort_n_i,
    input wire logic command_strobe_n_i,
    input wire logic write_strobe_out_n_o,
    input wire logic read_strobe_out_n_o,
    input wire logic filemark_seen_out_n_o,
    input wire logic data_busy_out_n_o,
    input wire logic formatter_busy_out_n_o,
    input wire logic status_oe_o
);
    // One clock domain; strobes are 40 cycles wide.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_wstr_width: assert property ($fell(write_strobe_out_n_o) |->
        ##39 !write_strobe_out_n_o ##1 write_strobe_out_n_o)
        else $error("write strobe width");
    chk_rstr_width: assert property ($fell(read_strobe_out_n_o) |->
        ##39 !read_strobe_out_n_o ##1 read_strobe_out_n_o)
        else $error("read strobe width");
    chk_wstr_busy: assert property ($fell(write_strobe_out_n_o) |-> !data_busy_out_n_o)
        else $error("write strobe while idle");
    chk_fmk_busy: assert property ($fell(filemark_seen_out_n_o) |-> !data_busy_out_n_o)
        else $error("file mark after busy");
    chk_busy_pair: assert property ($fell(data_busy_out_n_o) |-> !formatter_busy_out_n_o)
        else $error("formatter busy late");
    chk_fby_after: assert property ($rose(formatter_busy_out_n_o) |-> data_busy_out_n_o)
        else $error("formatter busy early");
    chk_abort_drop: assert property ($rose(runaway_abort_n_i) && status_oe_o |->
        ##[1:6] data_busy_out_n_o && formatter_busy_out_n_o)
        else $error("abort ignored");
    chk_go_trailing: assert property ($fell(formatter_busy_out_n_o) |->
        command_strobe_n_i && $past(command_strobe_n_i, 2))
        else $error("start before trailing edge");
endmodule : tfhi_properties
bind tfhi_drive tfhi_properties u_props (.*);
`default_nettype wire

// ---- bench/tfhi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tfhi_host (
    input wire logic clk_i,
    input wire logic wstr_n_i,
    output logic [2:0] unit_n_o,
    output logic go_n_o,
    output logic abort_n_o,
    output logic speed_n_o,
    output logic [4:0] code_n_o,
    output logic [9:0] char_n_o
);
    logic [9:0] char_q[$];
    initial {unit_n_o, go_n_o, abort_n_o, speed_n_o, code_n_o, char_n_o} = '1;
    // setup and width
    // Lines settle 41 cycles, over a microsecond, before and across the strobe.
    task automatic issue(input logic [2:0] u, input logic [4:0] code, input logic hi);
        @(posedge clk_i);
        {unit_n_o, code_n_o, speed_n_o} <= ~{u, code, hi};
        repeat (41) @(posedge clk_i);
        go_n_o <= 1'h0;
        repeat (41) @(posedge clk_i);
        go_n_o <= 1'h1;
    endtask : issue
    // Only the rising edge of abort acts on the drive.
    task automatic abort();
        @(posedge clk_i);
        abort_n_o <= 1'h0;
        repeat (41) @(posedge clk_i);
        abort_n_o <= 1'h1;
    endtask : abort
    // next character
    // The next character and its last flag follow each strobe's trailing edge.
    task automatic feed();
        char_n_o <= ~char_q.pop_front();
    endtask : feed
    always @(posedge wstr_n_i)
        if (char_q.size() != 0)
            feed();
endmodule : tfhi_host
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 0, arst_n_i = 0;
    logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [3:0] s_axi_wstrb = '1;
    logic rewind_pulse_n_i = 1, rewind_unload_pulse_n_i = 1;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, status_oe_o;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic unit_addr_high_n_i, unit_addr_mid_n_i, unit_addr_low_n_i, runaway_abort_n_i, command_strobe_n_i;
    wire logic speed_select_in_n_i, last_char_flag_n_i, write_parity_bit_n_i, write_cmd_line_n_i, reverse_cmd_line_n_i;
    wire logic filemark_cmd_line_n_i, edit_cmd_line_n_i, erase_cmd_line_n_i, write_strobe_out_n_o, read_strobe_out_n_o;
    wire logic [7:0] write_data_n_i, read_data_n_o;
    wire logic read_parity_bit_n_o, data_busy_out_n_o, formatter_busy_out_n_o, corrected_error_out_n_o;
    wire logic filemark_seen_out_n_o, id_burst_out_n_o, end_of_tape_out_n_o, load_point_out_n_o, write_protect_out_n_o;
    wire logic online_out_n_o, hard_error_out_n_o, drive_ready_out_n_o, rewinding_out_n_o, high_speed_out_n_o;
    int n_mismatch = 0, n_tests = 0, seed = 84177;
    logic [33:0] exp_q[$];
    logic [9:0] c, exp_c[$];
    tfhi_drive #(.WIN_LO_CYC(200), .WIN_HI_CYC(50), .REPOS_CYC(300)) dut (.*);
    tfhi_host host (.clk_i(sys_clk_i), .wstr_n_i(write_strobe_out_n_o | !status_oe_o),
        .unit_n_o({unit_addr_high_n_i, unit_addr_mid_n_i, unit_addr_low_n_i}), .go_n_o(command_strobe_n_i),
        .abort_n_o(runaway_abort_n_i), .speed_n_o(speed_select_in_n_i),
        .code_n_o({erase_cmd_line_n_i, edit_cmd_line_n_i, filemark_cmd_line_n_i, write_cmd_line_n_i,
        reverse_cmd_line_n_i}),
        .char_n_o({last_char_flag_n_i, write_parity_bit_n_i, write_data_n_i}));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    // An unselected drive leaves its lines to the bus pull-ups.
    function automatic logic pin(input logic x);
        return x | !status_oe_o;
    endfunction : pin
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge sys_clk_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        fork
            begin
                @(posedge sys_clk_i iff s_axi_awready);
                s_axi_awvalid <= 0;
            end
            begin
                @(posedge sys_clk_i iff s_axi_wready);
                s_axi_wvalid <= 0;
            end
        join
        @(posedge sys_clk_i iff s_axi_bvalid);
        s_axi_bready <= 0;
        chk("bresp", s_axi_bresp, r);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        @(posedge sys_clk_i iff s_axi_arready);
        s_axi_arvalid <= 0;
        @(posedge sys_clk_i iff s_axi_rvalid);
        s_axi_rready <= 0;
    endtask : rd
    // Each read answer is matched against the oldest note that rd left.
    always @(posedge sys_clk_i)
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    // The watchdog allows about fourteen times the cycles the tests need.
    initial begin
        #400_000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        arst_n_i <= 1;
        wr(5'h14, '0, 2'h2);
        rd(5'h00, '0);
        wr(5'h00, 32'h0000_011d, 2'h0);
        host.issue(3'h3, 5'h02, 1'h0);
        repeat (8) @(posedge sys_clk_i);
        chk("oe", status_oe_o, 1'h0);
        rd(5'h04, 34'h0000_4200);
        $display("test select done");
        host.issue(3'h5, 5'h02, 1'h0);
        repeat (8) @(posedge sys_clk_i);
        chk("busy", {pin(data_busy_out_n_o), pin(formatter_busy_out_n_o)}, 2'h0);
        for (int i = 0; i < 3; i++)
            host.char_q.push_back({i == 2, 9'($random(seed))});
        exp_c = host.char_q;
        host.feed();
        foreach (exp_c[i]) begin
            wr(5'h08, 32'h0000_0040, 2'h0);
            @(posedge sys_clk_i iff !pin(write_strobe_out_n_o));
            rd(5'h10, exp_c[i]);
            @(posedge write_strobe_out_n_o);
        end
        repeat (4) @(posedge sys_clk_i);
        chk("dby", pin(data_busy_out_n_o), 1'h1);
        repeat (150) @(posedge sys_clk_i);
        chk("fby", pin(formatter_busy_out_n_o), 1'h0);
        repeat (60) @(posedge sys_clk_i);
        chk("fby", pin(formatter_busy_out_n_o), 1'h1);
        $display("test write done");
        host.issue(3'h5, 5'h00, 1'h1);
        repeat (400) @(posedge sys_clk_i);
        chk("speed", pin(high_speed_out_n_o), 1'h0);
        c = 10'($random(seed)) & 10'h1ff;
        wr(5'h0c, 32'(c), 2'h0);
        @(posedge sys_clk_i iff !pin(read_strobe_out_n_o));
        chk("rpins", {read_parity_bit_n_o, read_data_n_o}, {~c[8:0]});
        rewind_unload_pulse_n_i <= 0;
        host.abort();
        repeat (8) @(posedge sys_clk_i);
        chk("busy", {pin(data_busy_out_n_o), pin(formatter_busy_out_n_o)}, 2'h3);
        rewind_unload_pulse_n_i <= 1;
        repeat (8) @(posedge sys_clk_i);
        chk("rwu", {pin(rewinding_out_n_o), pin(online_out_n_o)}, 2'h1);
        $display("test read abort done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
